/* File: hw/bso_frame_offset.sv */
// Purpose: delays one output's frame start against the frame reference
// Assumes: offsets already range limited by the configuration logic
// Notes:   a negative horizontal offset borrows one line from the vertical
`timescale 1ns/1ps
module bso_frame_offset
  import bso_pkg::*;
#(
  parameter int LW = 13,
  parameter int VW = 12,
  parameter int HW = 16
)(
  input  wire logic clk,
  input  wire logic rst,
  bso_tim_if.tim    t
);
  logic [LW-1:0]     rh;
  logic [VW-1:0]     rv;
  logic              running;
  logic signed [HW:0] hs;
  logic signed [HW:0] vs;
  logic [LW-1:0]     th;
  logic [VW-1:0]     tv;

  // ----------------------------------------
  // target position in reference coordinates
  // ----------------------------------------
  always_comb begin
    hs = (HW+1)'(t.hoff);
    vs = (HW+1)'(t.voff);
    if (hs < 0) begin
      hs = hs + $signed({{(HW+1-LW){1'b0}}, t.line_len});
      vs = vs - 17'sd1;
    end
    if (vs < 0) begin
      vs = vs + $signed({{(HW+1-VW){1'b0}}, t.period});
    end
    th = hs[LW-1:0];
    tv = vs[VW-1:0];
  end

  // ----------------------------------------
  // reference position counters
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst || t.restart) begin
      rh      <= '0;
      rv      <= '0;
      running <= 1'b0;
    end else if (t.ref_pulse) begin
      rh      <= '0;
      rv      <= '0;
      running <= 1'b1;
    end else if (rh >= t.line_len - LW'(1)) begin
      rh <= '0;
      rv <= (rv >= t.period - VW'(1)) ? '0 : rv + VW'(1);
    end else begin
      rh <= rh + LW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || t.restart) begin
      t.frame_start <= 1'b0;
    end else begin
      t.frame_start <= running && (rh == th) && (rv == tv);
    end
  end
endmodule : bso_frame_offset

/* File: hw/bso_pkg.sv */
// Purpose: shared constants and types for the black/sync output configuration block
// Assumes: one video sample clock; four reference outputs
// Notes:   register offsets are byte addresses on a 32-bit apb slave
package bso_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int OUTPUTS = 4;
  localparam int LW      = 13;
  localparam int VW      = 12;
  localparam int HW      = 16;

  // ----------------------------------------
  // enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    BSO_FMT_NTSC,
    BSO_FMT_NTSC_WITHOUT_PEDESTAL,
    BSO_FMT_PAL,
    BSO_FMT_HD_TRILEVEL_SYNC
  } bso_fmt_e;

  typedef enum logic [3:0] {
    BSO_SIG_BB,
    BSO_SIG_BB_FREF,
    BSO_SIG_BB_10FID,
    BSO_SIG_CB100,
    BSO_SIG_CB75,
    BSO_SIG_CB_SMPTE,
    BSO_SIG_FF40,
    BSO_SIG_OTHER1,
    BSO_SIG_OTHER2,
    BSO_SIG_BB_NO_FREF,
    BSO_SIG_CB100_RED,
    BSO_SIG_CB75_RED
  } bso_sig_e;

  typedef enum logic [3:0] {
    BSO_R1080_60I,
    BSO_R1080_59I,
    BSO_R1080_50I,
    BSO_R1080_24SF,
    BSO_R1080_23SF,
    BSO_R1080_30P,
    BSO_R1080_29P,
    BSO_R1080_25P,
    BSO_R1080_24P,
    BSO_R1080_23P,
    BSO_R720_60P,
    BSO_R720_59P,
    BSO_R720_50P
  } bso_rate_e;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_FORMAT = 12'h008;
  localparam logic [11:0] ADDR_SIGNAL = 12'h00c;
  localparam logic [11:0] ADDR_VOFF   = 12'h010;
  localparam logic [11:0] ADDR_HOFF   = 12'h014;

  localparam int CTRL_DEFAULT_BIT = 0;
  localparam int CTRL_ZERO_BIT    = 1;
  localparam int CTRL_CLR_REJ_BIT = 2;
  localparam int CTRL_SEL_LSB     = 4;
  localparam int STAT_OPTION_BIT  = 0;
  localparam int STAT_GENLOCK_BIT = 1;
  localparam int STAT_REJECT_BIT  = 2;

  localparam logic [1:0]        FMT_RST  = BSO_FMT_NTSC;
  localparam logic [3:0]        SIG_RST  = BSO_SIG_BB;
  localparam logic [3:0]        RATE_RST = BSO_R1080_60I;
  localparam logic [1:0]        SEL_RST  = 2'h0;
  localparam logic signed [15:0] HOFF_RST = 16'sh0000;
  localparam logic signed [11:0] VOFF_RST = 12'sh000;

  // ----------------------------------------
  // timing: step size and line/frame lengths
  // ----------------------------------------
  localparam int STEP_SD_PS = 18500;
  localparam int STEP_HD_PS = 13500;
  localparam logic [12:0] NTSC_LINE = 13'd3432;
  localparam logic [12:0] PAL_LINE  = 13'd3456;
  localparam logic [11:0] NTSC_CF   = 12'd1050;
  localparam logic [11:0] PAL_CF    = 12'd2500;
  localparam logic [11:0] HD1080_FR = 12'd1125;
  localparam logic [11:0] HD720_FR  = 12'd750;
  localparam logic [12:0] HD_LINE [0:12] = '{13'd2200, 13'd2200, 13'd2640, 13'd2750,
    13'd2750, 13'd2200, 13'd2200, 13'd2640, 13'd2750, 13'd2750, 13'd1650, 13'd1650,
    13'd1980};

  function automatic logic [12:0] bso_line_clocks(input logic [1:0] fmt,
                                                  input logic [3:0] sig);
    logic [12:0] r;
    r = NTSC_LINE;
    if (fmt == BSO_FMT_PAL) begin
      r = PAL_LINE;
    end else if (fmt == BSO_FMT_HD_TRILEVEL_SYNC && sig <= BSO_R720_50P) begin
      r = HD_LINE[sig];
    end
    return r;
  endfunction : bso_line_clocks

  function automatic logic [11:0] bso_period_lines(input logic [1:0] fmt,
                                                   input logic [3:0] sig);
    logic [11:0] r;
    r = NTSC_CF;
    if (fmt == BSO_FMT_PAL) begin
      r = PAL_CF;
    end else if (fmt == BSO_FMT_HD_TRILEVEL_SYNC) begin
      r = (sig >= BSO_R720_60P) ? HD720_FR : HD1080_FR;
    end
    return r;
  endfunction : bso_period_lines

endpackage : bso_pkg

/* File: hw/bso_sig_check.sv */
// Purpose: legality of a signal choice for an output, format and option state
// Assumes: encodings from bso_pkg
// Notes:   purely combinational
`timescale 1ns/1ps
module bso_sig_check
  import bso_pkg::*;
(
  input  wire logic [1:0] fmt,
  input  wire logic [3:0] sig,
  input  wire logic [1:0] out_idx,
  input  wire logic       option,
  output logic            valid
);
  logic opt_ok;

  always_comb begin
    opt_ok = option && (out_idx >= 2'd2);
    case (fmt)
      BSO_FMT_NTSC, BSO_FMT_NTSC_WITHOUT_PEDESTAL: begin
        if (sig == BSO_SIG_BB || sig == BSO_SIG_BB_FREF) begin
          valid = 1'b1;
        end else if (sig >= BSO_SIG_BB_10FID && sig <= BSO_SIG_OTHER2) begin
          valid = opt_ok;
        end else begin
          valid = 1'b0;
        end
      end
      BSO_FMT_PAL: begin
        if (sig == BSO_SIG_BB || sig == BSO_SIG_BB_NO_FREF) begin
          valid = 1'b1;
        end else if (sig == BSO_SIG_CB100 || sig == BSO_SIG_CB75 || sig == BSO_SIG_FF40
                     || sig == BSO_SIG_OTHER1 || sig == BSO_SIG_OTHER2
                     || sig == BSO_SIG_CB100_RED || sig == BSO_SIG_CB75_RED) begin
          valid = opt_ok;
        end else begin
          valid = 1'b0;
        end
      end
      BSO_FMT_HD_TRILEVEL_SYNC: begin
        valid = (sig <= BSO_R720_50P);
      end
      default: begin
        valid = 1'b0;
      end
    endcase
  end
endmodule : bso_sig_check

/* File: hw/bso_tim_if.sv */
// Purpose: per-output timing carrier between configuration and frame offset logic
// Assumes: one clock domain
// Notes:   ctl drives settings, tim returns the delayed frame start
`timescale 1ns/1ps
interface bso_tim_if #(
  parameter int LW = 13,
  parameter int VW = 12,
  parameter int HW = 16
);
  logic [LW-1:0]        line_len;
  logic [VW-1:0]        period;
  logic signed [HW-1:0] hoff;
  logic signed [VW-1:0] voff;
  logic                 restart;
  logic                 ref_pulse;
  logic                 frame_start;

  modport ctl (output line_len, period, hoff, voff, restart, ref_pulse, input frame_start);
  modport tim (input line_len, period, hoff, voff, restart, ref_pulse, output frame_start);
endinterface : bso_tim_if

/* File: hw/bso_top.sv */
// Purpose: apb configuration and timing offsets for four black/sync reference outputs
// Assumes: apb with 32-bit data; frame reference pins are asynchronous
// Notes:   one output is selected at a time for format, signal and offset access
`timescale 1ns/1ps

// Function
// - four outputs each keep their own format, signal and offsets, edited one at a time.
// - the format of an output is ntsc, ntsc without pedestal, pal or hd trilevel sync.
// - a format change may restart that output's timing abruptly.
// - the legal signal choices depend on the output's current format.
// - ntsc formats offer black burst and burst with field reference, extras with option.
// - pal offers black burst and burst without field reference, extras with option.
// - hd_trilevel_sync_format picks one of ten 1080-line rates or three 720-line rates.
// - option signals need the color bars option and only outputs three and four.
// - offsets count from the genlock frame when present, else from the internal frame.
// - ntsc or pal vertical offset is limited to half a color frame in line steps.
// - hd vertical offset is limited to half a frame in line steps.
// - horizontal offset spans minus to plus one line in whole clock steps.
// - a reset-offset request zeroes the selected output's timing offset.
// - a factory default sets all outputs to ntsc, black burst and zero offsets.
// - the color bars option shows as one status flag, one when present.
// - a horizontal request beyond one line carries the excess into the vertical offset.
module bso_top
  import bso_pkg::*;
#(
  parameter int N_OUT = bso_pkg::OUTPUTS
)(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      genlock_present_pin,
  input  wire logic                      genlock_frame_pin,
  input  wire logic                      color_bars_option_pin,
  input  wire logic                      internal_frame,
  output logic [bso_pkg::OUTPUTS-1:0][1:0] out_format,
  output logic [bso_pkg::OUTPUTS-1:0][3:0] out_signal,
  output logic [bso_pkg::OUTPUTS-1:0]      frame_start
);
  import bso_pkg::*;

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (N_OUT != OUTPUTS) begin : g_bad_outputs
    $error("bso_top serves exactly four outputs");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [1:0]           fmt_q   [OUTPUTS];
  logic [3:0]           sig_q   [OUTPUTS];
  logic signed [HW-1:0] hoff_q  [OUTPUTS];
  logic signed [VW-1:0] voff_q  [OUTPUTS];
  logic [OUTPUTS-1:0]   restart;
  logic [1:0]           sel_q;
  logic                 reject_q;
  logic [2:0]           s1;
  logic [2:0]           s2;
  logic [2:0]           s3;
  logic [2:0]           filt;
  logic                 gl_frame_d;
  logic                 gl_rise;
  logic                 ref_pulse;
  logic                 sig_valid;
  logic                 wr;
  logic [31:0]          rd_val;
  logic signed [HW-1:0] line_s;
  logic signed [HW-1:0] half_s;
  logic signed [HW-1:0] next_h;
  logic signed [HW-1:0] next_v;
  logic signed [HW-1:0] next_vw;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] reg_addr);
    return a == reg_addr;
  endfunction : is_addr

  function automatic logic mapped(input logic [11:0] a);
    return is_addr(a, ADDR_CTRL) || is_addr(a, ADDR_STATUS) || is_addr(a, ADDR_FORMAT)
           || is_addr(a, ADDR_SIGNAL) || is_addr(a, ADDR_VOFF) || is_addr(a, ADDR_HOFF);
  endfunction : mapped

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign wr      = psel && penable && pwrite && mapped(paddr);

  // ----------------------------------------
  // pin synchronisers: 0 genlock present, 1 genlock frame, 2 option
  // ----------------------------------------
  always_ff @(posedge clk) begin
    s1 <= {color_bars_option_pin, genlock_frame_pin, genlock_present_pin};
    s2 <= s1;
    s3 <= s2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      filt       <= 3'h0;
      gl_frame_d <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (s2[i] == s3[i]) begin
          filt[i] <= s3[i];
        end
      end
      gl_frame_d <= filt[1];
    end
  end

  assign gl_rise   = filt[1] && !gl_frame_d;
  assign ref_pulse = filt[0] ? gl_rise : internal_frame;

  // ----------------------------------------
  // signal legality for the selected output
  // ----------------------------------------
  bso_sig_check u_check (
    .fmt     (fmt_q[sel_q]),
    .sig     (pwdata[3:0]),
    .out_idx (sel_q),
    .option  (filt[2]),
    .valid   (sig_valid)
  );

  // ----------------------------------------
  // offset limiting and carry
  // ----------------------------------------
  always_comb begin
    line_s  = $signed({3'b000, bso_line_clocks(fmt_q[sel_q], sig_q[sel_q])});
    half_s  = $signed({4'h0, bso_period_lines(fmt_q[sel_q], sig_q[sel_q]) >> 1});
    next_h  = $signed(pwdata[HW-1:0]);
    next_v  = HW'(voff_q[sel_q]);
    next_vw = $signed(pwdata[HW-1:0]);
    if (next_h >= line_s) begin
      next_h = next_h - line_s;
      next_v = next_v + 16'sd1;
    end else if (next_h <= -line_s) begin
      next_h = next_h + line_s;
      next_v = next_v - 16'sd1;
    end
    if (next_h >= line_s) begin
      next_h = line_s - 16'sd1;
    end else if (next_h <= -line_s) begin
      next_h = 16'sd1 - line_s;
    end
    if (next_v > half_s) begin
      next_v = half_s;
    end else if (next_v < -half_s) begin
      next_v = -half_s;
    end
    if (next_vw > half_s) begin
      next_vw = half_s;
    end else if (next_vw < -half_s) begin
      next_vw = -half_s;
    end
  end

  // ----------------------------------------
  // output select and control
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= SEL_RST;
    end else if (wr && is_addr(paddr, ADDR_CTRL)) begin
      sel_q <= pwdata[CTRL_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reject_q <= 1'b0;
    end else if (wr && is_addr(paddr, ADDR_SIGNAL) && !sig_valid) begin
      reject_q <= 1'b1;
    end else if (wr && is_addr(paddr, ADDR_CTRL) && pwdata[CTRL_CLR_REJ_BIT]) begin
      reject_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // per-output configuration
  // ----------------------------------------
  always_ff @(posedge clk) begin
    restart <= '0;
    if (rst || (wr && is_addr(paddr, ADDR_CTRL) && pwdata[CTRL_DEFAULT_BIT])) begin
      for (int i = 0; i < OUTPUTS; i++) begin
        fmt_q[i]  <= FMT_RST;
        sig_q[i]  <= SIG_RST;
        hoff_q[i] <= HOFF_RST;
        voff_q[i] <= VOFF_RST;
      end
      restart <= '1;
    end else if (wr && is_addr(paddr, ADDR_CTRL) && pwdata[CTRL_ZERO_BIT]) begin
      hoff_q[pwdata[CTRL_SEL_LSB +: 2]] <= HOFF_RST;
      voff_q[pwdata[CTRL_SEL_LSB +: 2]] <= VOFF_RST;
    end else if (wr && is_addr(paddr, ADDR_FORMAT)) begin
      fmt_q[sel_q]   <= pwdata[1:0];
      sig_q[sel_q]   <= (pwdata[1:0] == BSO_FMT_HD_TRILEVEL_SYNC) ? RATE_RST : SIG_RST;
      hoff_q[sel_q]  <= HOFF_RST;
      voff_q[sel_q]  <= VOFF_RST;
      restart[sel_q] <= 1'b1;
    end else if (wr && is_addr(paddr, ADDR_SIGNAL) && sig_valid) begin
      sig_q[sel_q]   <= pwdata[3:0];
      restart[sel_q] <= 1'b1;
    end else if (wr && is_addr(paddr, ADDR_VOFF)) begin
      voff_q[sel_q] <= next_vw[VW-1:0];
    end else if (wr && is_addr(paddr, ADDR_HOFF)) begin
      hoff_q[sel_q] <= next_h;
      voff_q[sel_q] <= next_v[VW-1:0];
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_addr(paddr, ADDR_CTRL)) begin
      rd_val[CTRL_SEL_LSB +: 2] = sel_q;
    end else if (is_addr(paddr, ADDR_STATUS)) begin
      rd_val[STAT_OPTION_BIT]  = filt[2];
      rd_val[STAT_GENLOCK_BIT] = filt[0];
      rd_val[STAT_REJECT_BIT]  = reject_q;
    end else if (is_addr(paddr, ADDR_FORMAT)) begin
      rd_val[1:0] = fmt_q[sel_q];
    end else if (is_addr(paddr, ADDR_SIGNAL)) begin
      rd_val[3:0] = sig_q[sel_q];
    end else if (is_addr(paddr, ADDR_VOFF)) begin
      rd_val = 32'(voff_q[sel_q]);
    end else if (is_addr(paddr, ADDR_HOFF)) begin
      rd_val = 32'(hoff_q[sel_q]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_val;
    end
  end

  // ----------------------------------------
  // per-output timing
  // ----------------------------------------
  for (genvar g = 0; g < OUTPUTS; g++) begin : g_out
    bso_tim_if #(.LW(LW), .VW(VW), .HW(HW)) tif ();

    assign tif.line_len  = bso_line_clocks(fmt_q[g], sig_q[g]);
    assign tif.period    = bso_period_lines(fmt_q[g], sig_q[g]);
    assign tif.hoff      = hoff_q[g];
    assign tif.voff      = voff_q[g];
    assign tif.restart   = restart[g];
    assign tif.ref_pulse = ref_pulse;
    assign frame_start[g] = tif.frame_start;
    assign out_format[g]  = fmt_q[g];
    assign out_signal[g]  = sig_q[g];

    bso_frame_offset #(.LW(LW), .VW(VW), .HW(HW)) u_tim (
      .clk (clk),
      .rst (rst),
      .t   (tif.tim)
    );
  end
endmodule : bso_top

/* File: sim/bso_fw_model.sv */
// Purpose: firmware side model issuing apb transfers
// Assumes: called just after a rising edge
// Notes:   to rises when a transfer is never answered
`timescale 1ns/1ps
module bso_fw_model (
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic             to
);
  logic [31:0] rdata;
  logic        err;
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    to      = 1'b0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rdata = prdata;
    err   = pslverr;
    to      <= (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
endmodule : bso_fw_model

/* File: sim/bso_properties.sv */
// Purpose: port level checks of the output configuration block
// Assumes: apb access phase is psel and penable both high
// Notes:   sel mirrors the output select field of the control register
`timescale 1ns/1ps
module bso_properties
  import bso_pkg::*;
(
  input wire logic                           clk,
  input wire logic                           rst,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [11:0]                    paddr,
  input wire logic [31:0]                    pwdata,
  input wire logic [31:0]                    prdata,
  input wire logic                           pready,
  input wire logic                           pslverr,
  input wire logic [bso_pkg::OUTPUTS-1:0][1:0] out_format,
  input wire logic [bso_pkg::OUTPUTS-1:0][3:0] out_signal,
  input wire logic [bso_pkg::OUTPUTS-1:0]      frame_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic       acc;
  logic       legal;
  logic [1:0] sel;
  logic [1:0] fmt_q;
  assign acc = psel && penable;
  function automatic logic sig_ok(logic [1:0] f, logic [3:0] s, int i);
    if (f == BSO_FMT_HD_TRILEVEL_SYNC) return s <= 4'hc;
    if (f == BSO_FMT_PAL) return s inside {0, 9} || (i >= 2 && s inside {3, 4, 6, 7, 8, 10, 11});
    return s <= 4'h1 || (i >= 2 && s <= 4'h8);
  endfunction : sig_ok
  always_comb begin
    legal = 1'b1;
    for (int i = 0; i < OUTPUTS; i++) legal &= sig_ok(out_format[i], out_signal[i], i);
  end
  always_ff @(posedge clk) begin
    if (rst) sel <= 2'h0;
    else if (acc && pwrite && paddr == ADDR_CTRL) sel <= pwdata[5:4];
  end
  always_ff @(posedge clk) begin
    fmt_q <= pwdata[1:0];
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ready_zero_wait: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_error_unmapped: assert property (acc && paddr > ADDR_HOFF |-> pslverr)
    else $error("no error on unmapped address");
  a_error_idle: assert property (!acc |-> !pslverr)
    else $error("error outside access phase");
  a_read_steady: assert property (acc |=> $stable(prdata))
    else $error("read data moved after access");
  a_format_cause: assert property ($changed(out_format) |-> $past(acc) && $past(pwrite))
    else $error("format changed without a write");
  a_signal_cause: assert property ($changed(out_signal) |-> $past(acc) && $past(pwrite))
    else $error("signal changed without a write");
  a_signal_legal: assert property (legal)
    else $error("signal not legal for its output");
  a_single_start: assert property ((frame_start & $past(frame_start)) == '0)
    else $error("frame start wider than one cycle");
  a_default_recall: assert property (acc && pwrite && paddr == ADDR_CTRL && pwdata[0]
    |=> out_format == '0 && out_signal == '0) else $error("default recall incomplete");
  a_format_write: assert property (acc && pwrite && paddr == ADDR_FORMAT
    |=> out_format[sel] == fmt_q && out_signal[sel] == 4'h0) else $error("format write lost");
endmodule : bso_properties

bind bso_top bso_properties chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .out_format(out_format), .out_signal(out_signal),
  .frame_start(frame_start));

/* File: sim/tb_top.sv */
// Purpose: self checking bench of the output configuration block
// Assumes: 40 MHz clock, synchronous active high reset
// Notes:   one task per scenario
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import bso_pkg::*;
  logic                             clk = 1'b0;
  logic                             rst = 1'b1;
  logic                             gl_present = 1'b0;
  logic                             gl_frame = 1'b0;
  logic                             color_opt = 1'b1;
  logic                             int_frame = 1'b0;
  logic                             psel, penable, pwrite, pready, pslverr, fw_to;
  logic [11:0]                      paddr;
  logic [31:0]                      pwdata, prdata;
  logic [OUTPUTS-1:0][1:0]          out_format;
  logic [OUTPUTS-1:0][3:0]          out_signal;
  logic [OUTPUTS-1:0]               frame_start;
  int                               n_errors = 0;
  int                               samples_checked = 0;
  int                               t0, t3, n3;
  // output, format, signal, option, accepted
  logic [9:0] tbl [9] = '{{2'd0, 2'd0, 4'd1, 2'b11}, {2'd1, 2'd1, 4'd3, 2'b10},
    {2'd2, 2'd0, 4'd8, 2'b11}, {2'd3, 2'd1, 4'd5, 2'b00}, {2'd1, 2'd2, 4'd9, 2'b11},
    {2'd3, 2'd2, 4'd1, 2'b10}, {2'd3, 2'd2, 4'd11, 2'b11}, {2'd2, 2'd3, 4'd12, 2'b01},
    {2'd2, 2'd3, 4'd13, 2'b00}};
  always #12.5 clk = ~clk;
  bso_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .genlock_present_pin(gl_present), .genlock_frame_pin(gl_frame),
    .color_bars_option_pin(color_opt), .internal_frame(int_frame),
    .out_format(out_format), .out_signal(out_signal), .frame_start(frame_start));
  bso_fw_model fw (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .to(fw_to));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    fw.xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    fw.xfer(1'b0, a, 32'h0);
    `CHK(n, e, fw.rdata)
  endtask : rd
  task automatic watch;
    t0 = -1;
    t3 = -1;
    n3 = 0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      int_frame <= 1'b0;
      #1;
      if (frame_start[0] === 1'b1 && t0 < 0) t0 = i;
      if (frame_start[3] === 1'b1 && t3 < 0) t3 = i;
      if (frame_start[3] === 1'b1) n3++;
    end
  endtask : watch
  task automatic test_done;
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  always @(posedge fw_to) begin
    n_errors++;
    test_done;
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    `CHK("fmt_rst", 8'h0, out_format)
    rd(ADDR_FORMAT, 32'h0, "format_rst");
    rd(12'h040, 32'h0, "unmapped");
    `CHK("slverr", 1'b1, fw.err)
    rd(ADDR_STATUS, 32'h1, "opt_on");
    color_opt <= 1'b0;
    repeat (5) @(posedge clk);
    rd(ADDR_STATUS, 32'h0, "opt_off");
  endtask : t_reset
  task automatic t_format;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, 32'(k) << 4);
      wr(ADDR_FORMAT, 32'(k));
    end
    `CHK("fmt_each", 8'he4, out_format)
  endtask : t_format
  task automatic t_signal;
    logic [9:0] e;
    for (int i = 0; i < 9; i++) begin
      e = tbl[i];
      color_opt <= e[1];
      repeat (5) @(posedge clk);
      wr(ADDR_CTRL, {26'h0, e[9:8], 4'h4});
      wr(ADDR_FORMAT, {30'h0, e[7:6]});
      wr(ADDR_SIGNAL, {28'h0, e[5:2]});
      `CHK("signal", e[0] ? e[5:2] : 4'h0, out_signal[e[9:8]])
      rd(ADDR_STATUS, {29'h0, ~e[0], 1'b0, e[1]}, "reject");
    end
  endtask : t_signal
  task automatic t_offsets;
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_FORMAT, 32'h0);
    wr(ADDR_VOFF, 32'd600);
    rd(ADDR_VOFF, 32'd525, "voff_hi");
    wr(ADDR_VOFF, 32'hfffffda8);
    rd(ADDR_VOFF, 32'hfffffdf3, "voff_lo");
    wr(ADDR_VOFF, 32'h0);
    wr(ADDR_HOFF, 32'd3437);
    rd(ADDR_HOFF, 32'd5, "hoff_carry");
    rd(ADDR_VOFF, 32'd1, "voff_carry");
    wr(ADDR_HOFF, 32'hfffff298);
    rd(ADDR_VOFF, 32'd0, "voff_borrow");
    wr(ADDR_HOFF, 32'd3431);
    rd(ADDR_HOFF, 32'd3431, "hoff_max");
    wr(ADDR_VOFF, 32'd7);
    wr(ADDR_CTRL, 32'h2);
    rd(ADDR_HOFF, 32'h0, "hoff_zero");
    rd(ADDR_VOFF, 32'h0, "voff_zero");
    wr(ADDR_CTRL, 32'h10);
    wr(ADDR_FORMAT, 32'h3);
    wr(ADDR_SIGNAL, 32'ha);
    wr(ADDR_VOFF, 32'hfffffe70);
    rd(ADDR_VOFF, 32'hfffffe89, "voff_hd");
  endtask : t_offsets
  task automatic t_timing;
    color_opt <= 1'b1;
    wr(ADDR_CTRL, 32'h5);
    `CHK("sig_dflt", 16'h0, out_signal)
    rd(ADDR_VOFF, 32'h0, "voff_dflt");
    wr(ADDR_HOFF, 32'd5);
    int_frame <= 1'b1;
    watch();
    `CHK("start_lag", 1, t3)
    `CHK("start_hoff", 6, t0)
    gl_present <= 1'b1;
    repeat (5) @(posedge clk);
    rd(ADDR_STATUS, 32'h3, "genlock");
    int_frame <= 1'b1;
    watch();
    `CHK("int_ignored", 0, n3)
    gl_frame <= 1'b1;
    watch();
    `CHK("gl_start", 1, n3)
    gl_frame <= 1'b0;
  endtask : t_timing
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_format();
    t_signal();
    t_offsets();
    t_timing();
    test_done();
  end
endmodule : tb_top
